// [dzg_pkg.sv]
/*
  Shared constants for the doze and module clock gating block:
  register offsets, field positions, write masks, reset values,
  peripheral slot numbers and the CPU speed state encoding.
  Assumes a single 100 MHz core clock and a 16-bit register port.
*/
package dzg_pkg;
  // Register port geometry
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 16;
  // Register offsets on the plain register port
  localparam logic [3:0]  OFS_CLOCK_DIVIDER_REGISTER  = 4'h0;
  localparam logic [3:0]  OFS_GATE1   = 4'h1;
  localparam logic [3:0]  OFS_GATE2   = 4'h2;
  localparam logic [3:0]  OFS_GATE3   = 4'h3;
  localparam logic [3:0]  OFS_GATE4   = 4'h4;
  localparam logic [3:0]  OFS_GATE6   = 4'h6;
  localparam logic [3:0]  OFS_GATE7   = 4'h7;
  // Clock divider register fields
  localparam int          WAKE_BIT    = 15;
  localparam int          RATIO_MSB   = 14;
  localparam int          RATIO_LSB   = 12;
  localparam int          DOZE_BIT    = 11;
  localparam logic [2:0]  RATIO_RST   = 3'h0;
  // Implemented-bit masks of the gate registers
  localparam logic [15:0] GATE1_MASK  = 16'h3aa9;
  localparam logic [15:0] GATE2_MASK  = 16'h0303;
  localparam logic [15:0] GATE3_MASK  = 16'h0400;
  localparam logic [15:0] GATE4_MASK  = 16'h0008;
  localparam logic [15:0] GATE6_MASK  = 16'h0f00;
  localparam logic [15:0] GATE7_MASK  = 16'h0f00;
  localparam logic [15:0] GATE_RST    = 16'h0000;
  // Gate register bit positions
  localparam int          B_TMR3      = 13;
  localparam int          B_TMR2      = 12;
  localparam int          B_TMR1      = 11;
  localparam int          B_PWM       = 9;
  localparam int          B_I2C       = 7;
  localparam int          B_UART      = 5;
  localparam int          B_SPI       = 3;
  localparam int          B_ADC       = 0;
  localparam int          B_CAP2      = 9;
  localparam int          B_CAP1      = 8;
  localparam int          B_OC2       = 1;
  localparam int          B_OC1       = 0;
  localparam int          B_CMPALL    = 10;
  localparam int          B_REFCLK    = 3;
  localparam int          B_UNIT1     = 8;
  // Peripheral slot count and numbering
  localparam int          NPER        = 22;
  localparam int          P_PG1       = 14;
  localparam int          P_CMP1      = 18;
  // Divider counter width, enough for a ratio of 1:128
  localparam int          CNT_W       = 7;
  // CPU speed state
  typedef enum logic [0:0] {
    SPD_FULL = 1'b0,
    SPD_SLOW = 1'b1
  } dzg_speed_e;
endpackage

// [dzg_doze_div.sv]
/*
  CPU clock-enable divider for doze operation.
  Assumes the core clock feeds both domains; the CPU only advances
  on cycles where the tick output is high.
*/
`timescale 1ns/100ps
`default_nettype none
module dzg_doze_div
  import dzg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       slow,
  input  wire logic [2:0] ratio,
  output logic            tick
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // Phase within one slow period
    logic             tick;  // Registered CPU clock enable
  } dzg_div_s;

  dzg_div_s st;              // Current state
  dzg_div_s next_st;         // Next state
  logic [CNT_W-1:0] limit;   // Last phase of the period

  // Period of 2^ratio cycles, counted from zero
  always_comb begin
    limit   = CNT_W'((8'h01 << ratio) - 8'h01);
    next_st = st;
    if (!slow) begin
      // Full speed: tick every cycle, phase held at zero
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else if (st.cnt >= limit) begin
      // End of period: one CPU edge, phase restarts
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt  = st.cnt + CNT_W'(1);
      next_st.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{cnt: '0, tick: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule
`default_nettype wire

// [dzg_gate_apply.sv]
/*
  Per-peripheral clock enables, updated from the gate bits once per
  CPU instruction cycle. Assumes step is a one-cycle pulse on the
  core clock marking each instruction cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module dzg_gate_apply
  import dzg_pkg::*;
#(
  parameter logic [NPER-1:0] PRESENT = '1
)
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            step,
  input  wire logic [NPER-1:0] gate_req,
  input  wire logic [NPER-1:0] ctrl_on,
  output logic      [NPER-1:0] clk_en,
  output logic      [NPER-1:0] active
);
  typedef struct packed {
    logic [NPER-1:0] en;     // Applied clock enables
  } dzg_gate_s;

  dzg_gate_s st;             // Current state
  dzg_gate_s next_st;        // Next state
  logic [NPER-1:0] next_en;  // Per-slot next enable

  // One slot per peripheral
  for (genvar i = 0; i < NPER; i++) begin : g_slot
    // Missing parts never run; change lands on the instruction edge
    assign next_en[i] = step ? (PRESENT[i] & ~gate_req[i]) : st.en[i];
  end

  // Collect slots into the state copy
  always_comb begin
    next_st    = st;
    next_st.en = next_en;
  end

  // State register; present parts come out of reset enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{en: PRESENT};
    end else begin
      st <= next_st;
    end
  end

  assign clk_en = st.en;
  assign active = st.en & ctrl_on;
endmodule
`default_nettype wire

// [dzg_top.sv]
/*
  Doze and module clock gating top level: the clock divider register,
  six gate registers on a plain register port, the CPU clock enable
  divider and the per-peripheral clock enables.
  Assumes one core clock, an interrupt event pulse from the interrupt
  controller on the same clock, and peripherals that honour their
  clock enable and gated register write strobe.
*/
// Summary of operation
// - Slow CPU only while doze enable bit set
// - Three-bit ratio field, 1:1 to 1:128
// - Peripherals keep full-speed clock during doze
// - CPU edges aligned to peripheral clock edges
// - Wake bit returns CPU to full on interrupt
// - Wake bit clear: interrupts leave doze alone
// - Gate bit set stops peripheral clocks
// - Gated peripheral register writes are ignored
// - Enabled only if present and bit clear
// - Gate change takes effect one instruction later
// - Timer3, timer2, timer1 gate bits 13..11
// - SPI gate bit 3, ADC gate bit 0
// - Capture and compare gates, second register
// - Whole comparator gate, third register bit 10
// - Reference clock gate, fourth register bit 3
// - Pulse generator gates, sixth register 11..8
// - Comparator unit gates, seventh register 11..8
// - Unimplemented gate bits read zero, ignore writes
`timescale 1ns/100ps
`default_nettype none
module dzg_top
  import dzg_pkg::*;
#(
  parameter logic [NPER-1:0] PERIPH_PRESENT = '1
)
(
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  input  wire logic              IRQ_EVENT,
  input  wire logic [NPER-1:0]   PERIPH_CTRL_ON,
  input  wire logic [NPER-1:0]   PERIPH_SFR_WR,
  output logic                   CPU_CLK_EN,
  output logic                   CPU_SLOW,
  output logic      [NPER-1:0]   PERIPH_CLK_EN,
  output logic      [NPER-1:0]   PERIPH_ACTIVE,
  output logic      [NPER-1:0]   PERIPH_SFR_WR_OK
);

  // All register state of the block
  typedef struct packed {
    logic             wake;      // Wake to full speed on interrupt
    logic [2:0]       ratio;     // CPU divide code
    logic             doze;      // Doze enable
    logic [15:0]      gate1;     // Timers, PWM, serial, ADC gates
    logic [15:0]      gate2;     // Capture and compare gates
    logic [15:0]      gate3;     // Comparator module gate
    logic [15:0]      gate4;     // Reference clock gate
    logic [15:0]      gate6;     // Pulse generator gates
    logic [15:0]      gate7;     // Comparator unit gates
    logic [DATA_W-1:0] rdata;    // Read data, valid one cycle
    dzg_speed_e       speed;     // Reported CPU speed
  } dzg_top_s;

  dzg_top_s st;                  // Current state
  dzg_top_s next_st;             // Next state

  logic            wr_clock_divider_register;    // Write to clock divider register
  logic            wr_gate1;     // Write to first gate register
  logic            wr_gate2;     // Write to second gate register
  logic            wr_gate3;     // Write to third gate register
  logic            wr_gate4;     // Write to fourth gate register
  logic            wr_gate6;     // Write to sixth gate register
  logic            wr_gate7;     // Write to seventh gate register
  logic            irq_wake;     // Interrupt forces full speed
  logic            slow_req;     // Divided CPU clock requested
  logic            cpu_tick;     // One CPU clock edge
  logic [NPER-1:0] gate_req;     // Gate bits in slot order
  logic [NPER-1:0] per_en;       // Applied peripheral enables
  logic [15:0]     clock_divider_register_view;  // Clock divider register as read
  logic [15:0]     rd_mux;       // Selected read value

  // Write strobes per register
  assign wr_clock_divider_register = REG_WR && (REG_ADDR == OFS_CLOCK_DIVIDER_REGISTER);
  assign wr_gate1  = REG_WR && (REG_ADDR == OFS_GATE1);
  assign wr_gate2  = REG_WR && (REG_ADDR == OFS_GATE2);
  assign wr_gate3  = REG_WR && (REG_ADDR == OFS_GATE3);
  assign wr_gate4  = REG_WR && (REG_ADDR == OFS_GATE4);
  assign wr_gate6  = REG_WR && (REG_ADDR == OFS_GATE6);
  assign wr_gate7  = REG_WR && (REG_ADDR == OFS_GATE7);

  // Interrupt wake only when armed and dozing
  assign irq_wake = IRQ_EVENT && st.wake && st.doze;

  // Divide only while doze is on and ratio exceeds 1:1
  assign slow_req = st.doze && (st.ratio != RATIO_RST);

  // Clock divider register as software sees it
  always_comb begin
    clock_divider_register_view                      = '0;
    clock_divider_register_view[WAKE_BIT]            = st.wake;
    clock_divider_register_view[RATIO_MSB:RATIO_LSB] = st.ratio;
    clock_divider_register_view[DOZE_BIT]            = st.doze;
  end

  // Read mux; holes and unknown offsets read zero
  always_comb begin
    unique case (REG_ADDR)
      OFS_CLOCK_DIVIDER_REGISTER: begin
        rd_mux = clock_divider_register_view;
      end
      OFS_GATE1: begin
        rd_mux = st.gate1 & GATE1_MASK;
      end
      OFS_GATE2: begin
        rd_mux = st.gate2 & GATE2_MASK;
      end
      OFS_GATE3: begin
        rd_mux = st.gate3 & GATE3_MASK;
      end
      OFS_GATE4: begin
        rd_mux = st.gate4 & GATE4_MASK;
      end
      OFS_GATE6: begin
        rd_mux = st.gate6 & GATE6_MASK;
      end
      OFS_GATE7: begin
        rd_mux = st.gate7 & GATE7_MASK;
      end
      default: begin
        // Unmapped offset
        rd_mux = '0;
      end
    endcase
  end

  // Next-state logic for all registers
  always_comb begin
    next_st = st;

    // Read data stands only in the cycle after the read strobe
    if (REG_RD) begin
      next_st.rdata = rd_mux;
    end else begin
      next_st.rdata = '0;
    end

    // Clock divider register
    if (wr_clock_divider_register) begin
      // Software write wins over a coincident interrupt wake
      next_st.wake  = REG_WDATA[WAKE_BIT];
      next_st.ratio = REG_WDATA[RATIO_MSB:RATIO_LSB];
      next_st.doze  = REG_WDATA[DOZE_BIT];
    end else if (irq_wake) begin
      // Drop doze so the read-back shows full speed
      next_st.doze = 1'b0;
    end

    // Gate registers keep only implemented bits
    if (wr_gate1) begin
      next_st.gate1 = REG_WDATA & GATE1_MASK;
    end
    if (wr_gate2) begin
      next_st.gate2 = REG_WDATA & GATE2_MASK;
    end
    if (wr_gate3) begin
      next_st.gate3 = REG_WDATA & GATE3_MASK;
    end
    if (wr_gate4) begin
      next_st.gate4 = REG_WDATA & GATE4_MASK;
    end
    if (wr_gate6) begin
      next_st.gate6 = REG_WDATA & GATE6_MASK;
    end
    if (wr_gate7) begin
      next_st.gate7 = REG_WDATA & GATE7_MASK;
    end

    // Speed report follows the divider request
    unique case (st.speed)
      SPD_FULL: begin
        if (slow_req) begin
          next_st.speed = SPD_SLOW;
        end
      end
      SPD_SLOW: begin
        if (!slow_req) begin
          next_st.speed = SPD_FULL;
        end
      end
    endcase
  end

  // Register update
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st.wake  <= 1'b0;
      st.ratio <= RATIO_RST;
      st.doze  <= 1'b0;
      st.gate1 <= GATE_RST;
      st.gate2 <= GATE_RST;
      st.gate3 <= GATE_RST;
      st.gate4 <= GATE_RST;
      st.gate6 <= GATE_RST;
      st.gate7 <= GATE_RST;
      st.rdata <= '0;
      st.speed <= SPD_FULL;
    end else begin
      st <= next_st;
    end
  end

  // CPU clock enable; divider restarts on each entry to doze
  dzg_doze_div u_div (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .slow  (slow_req),
    .ratio (st.ratio),
    .tick  (cpu_tick)
  );

  // Gate bits gathered into peripheral slots
  always_comb begin
    gate_req     = '0;
    gate_req[0]  = st.gate1[B_ADC];
    gate_req[1]  = st.gate1[B_SPI];
    gate_req[2]  = st.gate1[B_UART];
    gate_req[3]  = st.gate1[B_I2C];
    gate_req[4]  = st.gate1[B_PWM];
    gate_req[5]  = st.gate1[B_TMR1];
    gate_req[6]  = st.gate1[B_TMR2];
    gate_req[7]  = st.gate1[B_TMR3];
    gate_req[8]  = st.gate2[B_OC1];
    gate_req[9]  = st.gate2[B_OC2];
    gate_req[10] = st.gate2[B_CAP1];
    gate_req[11] = st.gate2[B_CAP2];
    gate_req[12] = st.gate3[B_CMPALL];
    gate_req[13] = st.gate4[B_REFCLK];
    // Unit 1..4 sit on bits 8..11 of registers six and seven
    gate_req[P_PG1+3:P_PG1]   = st.gate6[B_UNIT1+3:B_UNIT1];
    gate_req[P_CMP1+3:P_CMP1] = st.gate7[B_UNIT1+3:B_UNIT1];
  end

  // Peripheral enables move on the next instruction edge
  dzg_gate_apply #(
    .PRESENT (PERIPH_PRESENT)
  ) u_gate (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .step     (cpu_tick),
    .gate_req (gate_req),
    .ctrl_on  (PERIPH_CTRL_ON),
    .clk_en   (per_en),
    .active   (PERIPH_ACTIVE)
  );

  // Read data from the register only
  assign REG_RDATA = st.rdata;

  // CPU advances only on divided edges
  assign CPU_CLK_EN = cpu_tick;

  // Divided state for the power manager
  assign CPU_SLOW = (st.speed == SPD_SLOW);

  // Peripheral clocks never see the divider, only their gate
  assign PERIPH_CLK_EN = per_en;

  // Register writes into a gated peripheral are dropped
  assign PERIPH_SFR_WR_OK = PERIPH_SFR_WR & per_en;

endmodule
`default_nettype wire

// [dzg_top_asserts.sv]
/*
  Port-level assertions and covers for dzg_top.
  Assumes one clock domain; bound into every dzg_top instance.
*/
`timescale 1ns/100ps
`default_nettype none
module dzg_top_chk
  import dzg_pkg::*;
#(
  parameter logic [NPER-1:0] PERIPH_PRESENT = '1
)
(
  input wire logic              CORE_CLK,
  input wire logic              RST_N,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic              REG_WR,
  input wire logic              REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire logic              IRQ_EVENT,
  input wire logic [NPER-1:0]   PERIPH_CTRL_ON,
  input wire logic [NPER-1:0]   PERIPH_SFR_WR,
  input wire logic              CPU_CLK_EN,
  input wire logic              CPU_SLOW,
  input wire logic [NPER-1:0]   PERIPH_CLK_EN,
  input wire logic [NPER-1:0]   PERIPH_ACTIVE,
  input wire logic [NPER-1:0]   PERIPH_SFR_WR_OK
);
  // Divider register write in this cycle
  wire logic divwr = REG_WR && REG_ADDR == OFS_CLOCK_DIVIDER_REGISTER;
  // Shadow of the wake enable bit
  logic      wake;
  // Track software writes of the wake bit
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wake <= 1'b0;
    end else if (divwr) begin
      wake <= REG_WDATA[WAKE_BIT];
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  doze_slow_a: assert property (
    (divwr && REG_WDATA[DOZE_BIT] && REG_WDATA[RATIO_MSB:RATIO_LSB] != 3'h0 && !IRQ_EVENT)
    ##1 (!divwr && !IRQ_EVENT) |=> CPU_SLOW) else $error("doze not entered");
  doze_clear_a: assert property (
    (divwr && !REG_WDATA[DOZE_BIT]) ##1 !divwr |=> !CPU_SLOW && CPU_CLK_EN)
    else $error("doze not left");
  slow_tick_a: assert property (
    CPU_SLOW |-> ##[0:128] CPU_CLK_EN) else $error("cpu tick missing");
  full_run_a: assert property (
    !CPU_SLOW && !$past(CPU_SLOW) |-> CPU_CLK_EN) else $error("full speed gap");
  irq_wake_a: assert property (
    IRQ_EVENT && wake && CPU_SLOW && !REG_WR |-> ##3 (!CPU_SLOW && CPU_CLK_EN)[*3])
    else $error("no wake on interrupt");
  irq_keep_a: assert property (
    IRQ_EVENT && !wake && CPU_SLOW && !REG_WR |=> CPU_SLOW) else $error("interrupt woke cpu");
  gate_tick_a: assert property (
    !$stable(PERIPH_CLK_EN) |-> $past(CPU_CLK_EN)) else $error("gate moved off tick");
  gate_delay_a: assert property (
    (REG_WR && REG_ADDR == OFS_GATE1) ##1 (CPU_CLK_EN && !REG_WR)
    |=> PERIPH_CLK_EN[0] == (!$past(REG_WDATA[0], 2) && PERIPH_PRESENT[0]))
    else $error("gate change late");
  absent_off_a: assert property (
    (PERIPH_CLK_EN & ~PERIPH_PRESENT) == '0) else $error("absent slot clocked");
  active_and_a: assert property (
    PERIPH_ACTIVE == (PERIPH_CLK_EN & PERIPH_CTRL_ON)) else $error("active mismatch");
  sfr_block_a: assert property (
    PERIPH_SFR_WR_OK == (PERIPH_SFR_WR & PERIPH_CLK_EN)) else $error("gated write passed");
  gate_read_a: assert property (
    $past(REG_RD && REG_ADDR == OFS_GATE1) |-> (REG_RDATA & ~GATE1_MASK) == '0)
    else $error("unimplemented bit read");
  // Main scenarios reached
  cover property (CPU_SLOW && IRQ_EVENT && wake);
  cover property ($fell(PERIPH_CLK_EN[4]));
  cover property (CPU_SLOW ##1 !CPU_SLOW);
endmodule
bind dzg_top dzg_top_chk #(.PERIPH_PRESENT(PERIPH_PRESENT)) chk_u (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ_EVENT(IRQ_EVENT),
  .PERIPH_CTRL_ON(PERIPH_CTRL_ON), .PERIPH_SFR_WR(PERIPH_SFR_WR), .CPU_CLK_EN(CPU_CLK_EN),
  .CPU_SLOW(CPU_SLOW), .PERIPH_CLK_EN(PERIPH_CLK_EN), .PERIPH_ACTIVE(PERIPH_ACTIVE),
  .PERIPH_SFR_WR_OK(PERIPH_SFR_WR_OK));
`default_nettype wire

// [dzg_periph_model.sv]
/*
  Behavioural peripheral side: own enable levels and register writes.
  Assumes the core clock and the per-slot clock enables of dzg_top.
*/
`timescale 1ns/100ps
`default_nettype none
module dzg_periph_model
  import dzg_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic [NPER-1:0] clk_en,
  output logic      [NPER-1:0] ctrl_on,
  output logic      [NPER-1:0] sfr_wr
);
  int   seed;     // Own random stream
  logic pwm_was;  // Last pwm clock enable
  initial seed = 32'h16cb23b5;
  // Random register writes, enables change now and then
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_wr  <= '0;
      ctrl_on <= '1;
      pwm_was <= 1'b1;
    end else begin
      // One-cycle setup write to pwm on every re-enable
      sfr_wr  <= NPER'($random(seed)) | (NPER'(clk_en[4] && !pwm_was) << 4);
      pwm_was <= clk_en[4];
      if ($random(seed) % 16 == 0) begin
        ctrl_on <= NPER'($random(seed));
      end
    end
  end
endmodule
`default_nettype wire

// [doze_and_module_clock_gating_bench.sv]
/*
  Self-checking bench: register map, gating, doze ratios, wake.
  Assumes dzg_top, dzg_periph_model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module doze_and_module_clock_gating_bench
  import dzg_pkg::*;
;
  localparam logic [NPER-1:0] PRES = 22'h3fff7f; // Timer3 missing
  logic            clk;
  logic            rst_n;
  logic [3:0]      addr;
  logic [15:0]     wdata;
  logic            wr;
  logic            rd;
  logic            irq;
  logic [15:0]     rdata;
  logic [NPER-1:0] ctrl_on, sfr_wr, en, act, ok;
  logic            cpu_en;
  logic            slow;
  int              failures;
  int              tests_run;
  int              seed;
  int              n;
  logic [15:0]     q;
  logic [15:0]     g [16];   // Expected register contents
  logic [3:0]      offs [8]; // Gate offsets, then unmapped ones
  dzg_top #(.PERIPH_PRESENT(PRES)) dut_u (
    .CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .IRQ_EVENT(irq), .PERIPH_CTRL_ON(ctrl_on),
    .PERIPH_SFR_WR(sfr_wr), .CPU_CLK_EN(cpu_en), .CPU_SLOW(slow), .PERIPH_CLK_EN(en),
    .PERIPH_ACTIVE(act), .PERIPH_SFR_WR_OK(ok));
  dzg_periph_model per_u (
    .clk(clk), .rst_n(rst_n), .clk_en(en), .ctrl_on(ctrl_on), .sfr_wr(sfr_wr));
  always #5 clk = ~clk;
  // Compare a register word
  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h got %h", nm, e, s);
    end
  endtask
  // Compare a per-slot vector
  task automatic chk_vec(input string nm, input logic [NPER-1:0] e, input logic [NPER-1:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h got %h", nm, e, s);
    end
  endtask
  // One write cycle
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One read cycle, data taken in the following cycle
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Count CPU clock enables over c cycles
  task automatic ticks(input int c, output int k);
    k = 0;
    repeat (c) begin
      @(posedge clk);
      #1;
      if (cpu_en === 1'b1) k++;
    end
  endtask
  // Implemented bits per offset
  function automatic logic [15:0] msk(input logic [3:0] a);
    case (a)
      OFS_CLOCK_DIVIDER_REGISTER: return 16'hf800;
      OFS_GATE1:  return GATE1_MASK;
      OFS_GATE2:  return GATE2_MASK;
      OFS_GATE3:  return GATE3_MASK;
      OFS_GATE4:  return GATE4_MASK;
      OFS_GATE6:  return GATE6_MASK;
      OFS_GATE7:  return GATE7_MASK;
      default:    return 16'h0000;
    endcase
  endfunction
  // Slot enables from the expected gate bits
  function automatic logic [NPER-1:0] exp_en();
    return ~{g[7][11:8], g[6][11:8], g[4][3], g[3][10], g[2][9], g[2][8], g[2][1], g[2][0],
             g[1][13], g[1][12], g[1][11], g[1][9], g[1][7], g[1][5], g[1][3], g[1][0]} & PRES;
  endfunction
  // All slot outputs at once
  task automatic chk_gates();
    chk_vec("clk en", exp_en(), en);
    chk_vec("active", exp_en() & ctrl_on, act);
    chk_vec("wr ok", sfr_wr & exp_en(), ok);
  endtask
  // Counts and verdict
  task automatic results();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    {wr, rd, irq} = 3'h0;
    {failures, tests_run, seed} = {32'h0, 32'h0, 32'h16cb23b5};
    offs = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h5, 4'hd};
    foreach (g[i]) g[i] = 16'h0000;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd_reg(4'(a), q);
      chk_reg("reset value", 16'h0000, q);
    end
    chk_vec("present", PRES, en);
    // All ones first, then random words, unmapped offsets among them
    for (int i = 0; i < 48; i++) begin
      logic [3:0]  a;
      logic [15:0] d;
      a = (i < 8) ? offs[i] : offs[$unsigned($random(seed)) % 8];
      d = (i < 8) ? 16'hffff : 16'($random(seed));
      wr_reg(a, d);
      g[a] = d & msk(a);
      rd_reg(a, q);
      chk_reg("gate reg", g[a], q);
      chk_gates();
    end
    for (int i = 0; i < 6; i++) begin
      wr_reg(offs[i], 16'h0000);
      g[offs[i]] = 16'h0000;
    end
    rd_reg(OFS_GATE1, q);
    chk_gates();
    // Every ratio code, periodic CPU enable
    for (int r = 0; r < 8; r++) begin
      wr_reg(OFS_CLOCK_DIVIDER_REGISTER, 16'h0800 | 16'(r << 12));
      ticks((1 << r) + 4, n);
      ticks(4 << r, n);
      chk_reg("cpu ticks", 16'h0004, 16'(n));
      chk_reg("slow flag", 16'(r != 0), 16'(slow));
    end
    // Gate change while divided by 128
    wr_reg(OFS_GATE1, 16'h0001);
    g[1] = 16'h0001;
    ticks(131, n);
    chk_gates();
    wr_reg(OFS_CLOCK_DIVIDER_REGISTER, 16'h7000);
    ticks(4, n);
    ticks(8, n);
    chk_reg("full ticks", 16'h0008, 16'(n));
    // Interrupt without and with wake enabled
    for (int w = 0; w < 2; w++) begin
      wr_reg(OFS_CLOCK_DIVIDER_REGISTER, {w[0], 15'h3800});
      ticks(12, n);
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      ticks(5, n);
      chk_reg("slow after irq", 16'(w == 0), 16'(slow));
      rd_reg(OFS_CLOCK_DIVIDER_REGISTER, q);
      chk_reg("divider after irq", w ? 16'hb000 : 16'h3800, q);
    end
    // Reset in mid-run
    wr_reg(OFS_GATE6, 16'hffff);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (g[i]) g[i] = 16'h0000;
    rd_reg(OFS_GATE6, q);
    chk_reg("gate after reset", 16'h0000, q);
    chk_gates();
    results();
  end
  // Hang guard
  initial begin
    #100000;
    failures++;
    results();
  end
endmodule
`default_nettype wire
